// [bsb_pkg.sv]
// Package for the bridge sideband block: register map, field positions,
// reset values and timing counts.
// Assumes a 32-bit APB slave and a core clock of 100 MHz.
package bsb_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CLKCTRL = 8'h04;
  localparam logic [7:0] OFS_GPIO_OE = 8'h08;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h0c;
  localparam logic [7:0] OFS_GPIO_IN = 8'h10;
  localparam logic [7:0] OFS_HSCS = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_SBR = 0;
  localparam int CTRL_CHIP = 1;
  localparam int CTRL_PWR_LO = 4;
  localparam int HSCS_LED = 0;
  localparam int HSCS_PEND = 1;
  localparam int HSCS_EN = 2;
  localparam int ST_CAP66 = 0;
  localparam int ST_PRI66 = 1;
  localparam int ST_SEC66 = 2;
  localparam int ST_DIV = 3;
  localparam int ST_SHIFT = 4;
  localparam int ST_SRST_N = 5;
  localparam int ST_PCC = 6;
  localparam int ST_HS_EN = 7;

  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [1:0] PWR_D0 = 2'h0;
  localparam logic [1:0] PWR_D3HOT = 2'h3;
  localparam logic [3:0] GPIO_RST = 4'h0;
  localparam int NUM_SCLK = 10;
  localparam int NUM_GPIO = 4;
  localparam int EJECT_PIN = 3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int SRST_WAIT_US = 100;
  localparam int SRST_WAIT_CYC = SRST_WAIT_US * CLK_MHZ;
  localparam int CNT_W = 16;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [0:0] {
    MSK_SHIFT,
    MSK_DONE
  } bsb_msk_state_type;

endpackage

// [bsb_sync.sv]
// Two flip-flop synchroniser for a bus of level signals.
// Assumes each bit is a slow level; multi-bit values are not coherent.
`timescale 1ns/10ps
`default_nettype none
module bsb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // bsb_sync
`default_nettype wire

// [bsb_sideband.sv]
// Sideband control of a bus-to-bus bridge: straps, secondary clock mask,
// secondary reset timing, clock outputs, GPIO and hot-swap signalling.
// Assumes core_clk runs at twice the primary bus clock, so a clock output
// that toggles every core cycle runs at the primary bus frequency.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module bsb_sideband
  import bsb_pkg::*;
#(
  parameter int RST_WAIT_CYC = SRST_WAIT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps
  input wire logic speed_capability_strap,
  input wire logic primary_speed_enable,
  input wire logic power_clock_control_strap,
  input wire logic mode_select_zero,
  input wire logic mode_select_one,
  input wire logic clock_mask_serial_in,
  // Secondary speed line, open drain
  input wire logic secondary_speed_enable_in,
  output logic secondary_speed_enable_out,
  output logic secondary_speed_enable_oe_n,
  // Secondary clocks and reset
  output logic [NUM_SCLK-1:0] sec_clk_out,
  output logic sec_rst_n,
  // General purpose pins
  input wire logic [NUM_GPIO-1:0] gpio_in,
  output logic [NUM_GPIO-1:0] gpio_out,
  output logic [NUM_GPIO-1:0] gpio_oe_n,
  // Hot-swap
  output logic hotswap_enum_n,
  output logic hotswap_status_led
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NSYNC = 7 + NUM_GPIO;
  logic [NSYNC-1:0] sync_raw;
  logic [NSYNC-1:0] sync_val;
  logic cap66_s, pri_en_s, pcc_s, ms0_s, ms1_s, mask_s, sec_en_s;
  logic [NUM_GPIO-1:0] gpio_s;

  assign sync_raw = {gpio_in, secondary_speed_enable_in,
                     clock_mask_serial_in, mode_select_one,
                     mode_select_zero, power_clock_control_strap,
                     primary_speed_enable, speed_capability_strap};
  assign {gpio_s, sec_en_s, mask_s, ms1_s, ms0_s, pcc_s, pri_en_s,
          cap66_s} = sync_val;

  bsb_sync #(
    .W(NSYNC)
  ) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(sync_raw),
    .sync_out(sync_val)
  );

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  logic hs_en;
  logic pri66;
  logic sec66;
  logic half_rate;

  assign hs_en = !ms0_s && ms1_s;
  assign pri66 = pri_en_s && cap66_s;
  assign sec66 = sec_en_s && pri66;
  assign half_rate = !sec_en_s && pri_en_s;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic sbr_q, sbr_d;
  logic chip_q, chip_d;
  logic [1:0] pwr_q, pwr_d;
  logic [NUM_SCLK-1:0] clk_dis_q, clk_dis_d;
  logic [NUM_GPIO-1:0] goe_q, goe_d;
  logic [NUM_GPIO-1:0] gdo_q, gdo_d;
  logic led_q, led_d;
  logic pend_q, pend_d;
  logic pready_d, pslverr_d;
  logic [31:0] prdata_d;
  logic wr_en, rd_phase;
  logic [31:0] rdval;
  logic unmapped;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  // The answer comes one cycle into the access phase; writes land on the
  // edge where pready is seen high, so a write is never applied twice.
  assign rd_phase = psel && penable && !pready;
  assign wr_en = psel && penable && pwrite && pready;

  // ****************************************************************
  // Clock mask shifter
  // ****************************************************************
  bsb_msk_state_type msk_q, msk_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [NUM_SCLK-1:0] sh_q, sh_d;
  logic shifting;

  assign shifting = (msk_q == MSK_SHIFT);

  always_comb begin
    msk_d = msk_q;
    bit_cnt_d = bit_cnt_q;
    sh_d = sh_q;
    unique case (msk_q)
      MSK_SHIFT: begin
        // The first cycles would shift in the synchroniser's reset value,
        // so bits are taken only once the mask input has crossed it.
        if (bit_cnt_q >= 4'(SYNC_STAGES)) begin
          sh_d = {sh_q[NUM_SCLK-2:0], mask_s};
        end
        bit_cnt_d = bit_cnt_q + 4'h1;
        if (bit_cnt_q == 4'(NUM_SCLK + SYNC_STAGES - 1)) begin
          msk_d = MSK_DONE;
        end
      end
      MSK_DONE: begin
        bit_cnt_d = bit_cnt_q;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      msk_q <= MSK_SHIFT;
      bit_cnt_q <= 4'h0;
      sh_q <= '0;
    end else begin
      msk_q <= msk_d;
      bit_cnt_q <= bit_cnt_d;
      sh_q <= sh_d;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic ej_q, ej_d;
  logic ej_evt;
  logic primed;

  // Edges are believed only once the pin and its last value have both
  // crossed the synchroniser; otherwise reset itself looks like an event.
  assign primed = !shifting || (bit_cnt_q > 4'(SYNC_STAGES));
  // Both edges of the synchronised ejector count as an event.
  assign ej_evt = hs_en && primed && (ej_q != gpio_s[EJECT_PIN]);

  always_comb begin
    sbr_d = sbr_q;
    chip_d = chip_q && (cnt_q != '0);
    pwr_d = pwr_q;
    clk_dis_d = clk_dis_q;
    goe_d = goe_q;
    gdo_d = gdo_q;
    led_d = led_q;
    pend_d = pend_q;
    ej_d = gpio_s[EJECT_PIN];
    if (shifting && msk_d == MSK_DONE) begin
      clk_dis_d = sh_d;
    end
    if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: begin
          sbr_d = pwdata[CTRL_SBR];
          if (pwdata[CTRL_CHIP]) begin
            chip_d = 1'b1;
          end
          pwr_d = pwdata[CTRL_PWR_LO +: 2];
        end
        OFS_CLKCTRL: clk_dis_d = pwdata[NUM_SCLK-1:0];
        OFS_GPIO_OE: goe_d = pwdata[NUM_GPIO-1:0];
        OFS_GPIO_OUT: gdo_d = pwdata[NUM_GPIO-1:0];
        OFS_HSCS: begin
          led_d = pwdata[HSCS_LED];
          if (pwdata[HSCS_PEND]) begin
            pend_d = 1'b0;
          end
        end
        default: begin
          sbr_d = sbr_q;
        end
      endcase
    end
    // A new event wins over a clear in the same cycle.
    if (ej_evt) begin
      pend_d = 1'b1;
    end
  end

  always_comb begin
    rdval = '0;
    unmapped = 1'b0;
    unique case (paddr)
      OFS_CTRL: begin
        rdval[CTRL_SBR] = sbr_q;
        rdval[CTRL_CHIP] = chip_q;
        rdval[CTRL_PWR_LO +: 2] = pwr_q;
      end
      OFS_CLKCTRL: rdval[NUM_SCLK-1:0] = clk_dis_q;
      OFS_GPIO_OE: rdval[NUM_GPIO-1:0] = goe_q;
      OFS_GPIO_OUT: rdval[NUM_GPIO-1:0] = gdo_q;
      OFS_GPIO_IN: rdval[NUM_GPIO-1:0] = gpio_s;
      OFS_HSCS: begin
        rdval[HSCS_LED] = led_q;
        rdval[HSCS_PEND] = pend_q;
        rdval[HSCS_EN] = hs_en;
      end
      OFS_STATUS: begin
        rdval[ST_CAP66] = cap66_s;
        rdval[ST_PRI66] = pri66;
        rdval[ST_SEC66] = sec66;
        rdval[ST_DIV] = half_rate;
        rdval[ST_SHIFT] = shifting;
        rdval[ST_SRST_N] = sec_rst_n;
        rdval[ST_PCC] = pcc_s;
        rdval[ST_HS_EN] = hs_en;
      end
      default: unmapped = 1'b1;
    endcase
    pready_d = rd_phase;
    prdata_d = (rd_phase && !pwrite) ? rdval : '0;
    pslverr_d = rd_phase && unmapped;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sbr_q <= 1'b0;
      chip_q <= 1'b0;
      pwr_q <= PWR_D0;
      clk_dis_q <= '0;
      goe_q <= GPIO_RST;
      gdo_q <= GPIO_RST;
      led_q <= 1'b0;
      pend_q <= 1'b0;
      ej_q <= 1'b0;
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      sbr_q <= sbr_d;
      chip_q <= chip_d;
      pwr_q <= pwr_d;
      clk_dis_q <= clk_dis_d;
      goe_q <= goe_d;
      gdo_q <= gdo_d;
      led_q <= led_d;
      pend_q <= pend_d;
      ej_q <= ej_d;
      pready <= pready_d;
      prdata <= prdata_d;
      pslverr <= pslverr_d;
    end
  end

  // ****************************************************************
  // Secondary reset timing
  // ****************************************************************
  logic srst_n_d;
  logic hold;
  logic chip_set;

  assign chip_set = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_CHIP];
  assign hold = shifting || sbr_q;

  // The wait restarts whenever a hold source is active, so the release
  // always follows the last hold by the full period.
  always_comb begin
    cnt_d = cnt_q;
    if (hold || chip_set) begin
      cnt_d = CNT_W'(RST_WAIT_CYC);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
    srst_n_d = !hold && !chip_set && (cnt_d == '0);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= CNT_W'(RST_WAIT_CYC);
      sec_rst_n <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sec_rst_n <= srst_n_d;
    end
  end

  // ****************************************************************
  // Secondary clock outputs
  // ****************************************************************
  logic div_q, div_d;
  logic ph_q, ph_d;
  logic b2;
  logic [NUM_SCLK-1:0] sclk_d;

  assign b2 = pcc_s && (pwr_q == PWR_D3HOT);

  always_comb begin
    div_d = !div_q;
    ph_d = ph_q;
    if (!half_rate || div_q) begin
      ph_d = !ph_q;
    end
    for (int i = 0; i < NUM_SCLK; i++) begin
      if (b2) begin
        sclk_d[i] = 1'b0;
      end else if (clk_dis_q[i]) begin
        sclk_d[i] = 1'b1;
      end else begin
        sclk_d[i] = ph_q;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 1'b0;
      ph_q <= 1'b0;
      sec_clk_out <= '0;
    end else begin
      div_q <= div_d;
      ph_q <= ph_d;
      sec_clk_out <= sclk_d;
    end
  end

  // ****************************************************************
  // Pins: secondary speed line, GPIO and hot-swap
  // ****************************************************************
  logic spd_oe_n_d;
  logic [NUM_GPIO-1:0] goe_n_d;

  // Pulled low only while the secondary side is held in reset and primary_speed_enable is low.
  assign spd_oe_n_d = !(!sec_rst_n && !pri_en_s);

  always_comb begin
    goe_n_d = ~goe_q;
    if (hs_en) begin
      goe_n_d[EJECT_PIN] = 1'b1;
    end
  end

  // The strap is not yet known while the async reset is held, so the
  // line is pulled low then as the safe choice for a slow bus.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      secondary_speed_enable_out <= 1'b0;
      secondary_speed_enable_oe_n <= 1'b0;
      gpio_out <= GPIO_RST;
      gpio_oe_n <= '1;
      hotswap_enum_n <= 1'b1;
      hotswap_status_led <= 1'b0;
    end else begin
      secondary_speed_enable_out <= 1'b0;
      secondary_speed_enable_oe_n <= spd_oe_n_d;
      gpio_out <= gdo_q;
      gpio_oe_n <= goe_n_d;
      hotswap_enum_n <= !pend_q;
      hotswap_status_led <= led_q;
    end
  end

endmodule // bsb_sideband
`default_nettype wire

// [bsb_sideband_monitor.sv]
// Checker for the sideband block, bound to every instance of it.
// Assumes an APB master that holds its request until pready.
`timescale 1ns/10ps
`default_nettype none
module bsb_sideband_monitor
  import bsb_pkg::*;
#(
  parameter int RST_WAIT_CYC = SRST_WAIT_CYC
) (
  // Clock, reset and APB
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Straps and pins
  input wire logic primary_speed_enable,
  input wire logic power_clock_control_strap,
  input wire logic mode_select_zero,
  input wire logic mode_select_one,
  input wire logic secondary_speed_enable_oe_n,
  input wire logic [NUM_SCLK-1:0] sec_clk_out,
  input wire logic sec_rst_n,
  input wire logic [NUM_GPIO-1:0] gpio_in,
  input wire logic [NUM_GPIO-1:0] gpio_oe_n,
  input wire logic hotswap_enum_n,
  input wire logic hotswap_status_led
);
  logic wr;
  logic hs;
  logic led_q, led_d;
  logic [1:0] pwr_q, pwr_d;
  logic [15:0] cyc_q, cyc_d;
  assign wr = psel && penable && pready && pwrite;
  assign hs = !mode_select_zero && mode_select_one;
  // The cycle count saturates so a long run never wraps into the window.
  always_comb begin
    led_d = led_q;
    pwr_d = pwr_q;
    cyc_d = (cyc_q == 16'hffff) ? cyc_q : cyc_q + 16'h1;
    if (wr && paddr == OFS_HSCS) led_d = pwdata[HSCS_LED];
    if (wr && paddr == OFS_CTRL) pwr_d = pwdata[CTRL_PWR_LO +: 2];
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      led_q <= 1'b0;
      pwr_q <= PWR_D0;
      cyc_q <= 16'h0;
    end else begin
      led_q <= led_d;
      pwr_q <= pwr_d;
      cyc_q <= cyc_d;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_pready_once: assert property (pready |=> !pready)
    else $error("pready held");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr > OFS_STATUS))
    else $error("pslverr wrong");
  a_led_follow: assert property (
    wr && paddr == OFS_HSCS |=> ##[0:1] hotswap_status_led == led_q)
    else $error("led wrong");
  a_srst_hold: assert property (cyc_q < RST_WAIT_CYC + 8 |-> !sec_rst_n)
    else $error("sec reset early");
  a_srst_release: assert property (
    cyc_q == RST_WAIT_CYC + 16 |-> sec_rst_n)
    else $error("sec reset late");
  a_speed_drive: assert property (
    (!sec_rst_n && !primary_speed_enable)[*5] |->
    !secondary_speed_enable_oe_n)
    else $error("speed line free");
  a_speed_free: assert property (
    primary_speed_enable[*5] |-> secondary_speed_enable_oe_n)
    else $error("speed line driven");
  a_b2_stop: assert property (
    (power_clock_control_strap && pwr_q == PWR_D3HOT)[*4] |->
    sec_clk_out == '0)
    else $error("clocks not stopped");
  a_eject_input: assert property (hs[*4] |-> gpio_oe_n[EJECT_PIN])
    else $error("ejector pin driven");
  a_enum_event: assert property (
    hs[*3] ##0 $changed(gpio_in[EJECT_PIN]) |-> ##[2:6] !hotswap_enum_n)
    else $error("enum not raised");
  c_hscs_write: cover property (wr && paddr == OFS_HSCS);
  c_srst_rise: cover property ($rose(sec_rst_n));
  c_enum_low: cover property (hs && !hotswap_enum_n);
endmodule // bsb_sideband_monitor
bind bsb_sideband bsb_sideband_monitor #(.RST_WAIT_CYC(RST_WAIT_CYC)) u_mon (
  .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .primary_speed_enable(primary_speed_enable),
  .power_clock_control_strap(power_clock_control_strap),
  .mode_select_zero(mode_select_zero), .mode_select_one(mode_select_one),
  .secondary_speed_enable_oe_n(secondary_speed_enable_oe_n),
  .sec_clk_out(sec_clk_out), .sec_rst_n(sec_rst_n), .gpio_in(gpio_in),
  .gpio_oe_n(gpio_oe_n), .hotswap_enum_n(hotswap_enum_n),
  .hotswap_status_led(hotswap_status_led)
);
`default_nettype wire

// [bsb_board.sv]
// Board model: pulled-up secondary speed line, a slow agent, GPIO wiring.
// Assumes the block's enables are active low.
`timescale 1ns/10ps
`default_nettype none
module bsb_board
  import bsb_pkg::*;
(
  // Block side
  input wire logic speed_out,
  input wire logic speed_oe_n,
  input wire logic [NUM_GPIO-1:0] pin_out,
  input wire logic [NUM_GPIO-1:0] pin_oe_n,
  // Board side
  input wire logic agent_slow,
  input wire logic [NUM_GPIO-1:0] board_drive,
  output logic speed_line,
  output logic [NUM_GPIO-1:0] pin_level
);
  // Any agent pulling low wins over the pull-up.
  assign speed_line = !(agent_slow || (!speed_oe_n && !speed_out));
  // The board lets go of a pin the block drives; bit 3 is the ejector.
  always_comb begin
    for (int i = 0; i < NUM_GPIO; i++) begin
      pin_level[i] = pin_oe_n[i] ? board_drive[i] : pin_out[i];
    end
  end
endmodule // bsb_board
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the sideband block, driven over APB.
// Assumes the board model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import bsb_pkg::*;
  localparam int RW = 20;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, sp_out, sp_oe_n, sp_line, srst_n, enum_n, led;
  logic cap = 1'b1, pri = 1'b1, pcc = 1'b1, ms0 = 1'b0, ms1 = 1'b1;
  logic msk = 1'b0, slow = 1'b0;
  logic [3:0] ext = 4'hf, g_out, g_oe_n, g_in;
  logic [NUM_SCLK-1:0] sclk;
  int fails = 0, tests_run = 0, n;
  always #5 core_clk = ~core_clk;
  bsb_sideband #(.RST_WAIT_CYC(RW)) u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .speed_capability_strap(cap),
    .primary_speed_enable(pri), .power_clock_control_strap(pcc),
    .mode_select_zero(ms0), .mode_select_one(ms1),
    .clock_mask_serial_in(msk), .secondary_speed_enable_in(sp_line),
    .secondary_speed_enable_out(sp_out),
    .secondary_speed_enable_oe_n(sp_oe_n), .sec_clk_out(sclk),
    .sec_rst_n(srst_n), .gpio_in(g_in), .gpio_out(g_out),
    .gpio_oe_n(g_oe_n), .hotswap_enum_n(enum_n),
    .hotswap_status_led(led)
  );
  bsb_board u_board (
    .speed_out(sp_out), .speed_oe_n(sp_oe_n), .pin_out(g_out),
    .pin_oe_n(g_oe_n), .agent_slow(slow), .board_drive(ext),
    .speed_line(sp_line), .pin_level(g_in)
  );
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  // The request stands until pready is seen; only the watchdog ends a hang.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next request never re-drives psel in this step.
    @(posedge core_clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic tog(input int e);
    int t;
    logic p;
    t = 0;
    p = sclk[0];
    repeat (8) begin
      @(posedge core_clk);
      if (sclk[0] !== p) t++;
      p = sclk[0];
    end
    chk("toggles", e, t);
  endtask
  task automatic wsr();
    n = 0;
    while (srst_n !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk("srst_delay", 1, n >= RW + 8 && n <= RW + 20);
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    complete_run();
  end
  initial begin
    wt(2);
    arst_n <= 1'b1;
    wsr();
    chk("enum_n", 32'h1, 32'(enum_n));
    rdc("mask", OFS_CLKCTRL, 32'h0);
    tog(8);
    rdc("status", OFS_STATUS, 32'he7);
    slow <= 1'b1;
    wt(5);
    tog(4);
    rdc("status", OFS_STATUS, 32'heb);
    apb(1'b1, OFS_CTRL, 32'h30);
    wt(5);
    tog(0);
    chk("b2_clk", 32'h0, 32'(sclk));
    pcc <= 1'b0;
    wt(5);
    tog(4);
    slow <= 1'b0;
    cap <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0);
    wt(4);
    rdc("status", OFS_STATUS, 32'ha0);
    apb(1'b1, OFS_GPIO_OE, 32'hf);
    apb(1'b1, OFS_GPIO_OUT, 32'h5);
    wt(4);
    chk("gpio_oe_n", 32'h8, 32'(g_oe_n));
    chk("gpio_out", 32'h5, 32'(g_out));
    rdc("gpio_in", OFS_GPIO_IN, 32'hd);
    ext <= 4'h7;
    wt(8);
    chk("enum_n", 32'h0, 32'(enum_n));
    rdc("hscs", OFS_HSCS, 32'h6);
    apb(1'b1, OFS_HSCS, 32'h3);
    wt(2);
    chk("enum_n", 32'h1, 32'(enum_n));
    chk("led", 32'h1, 32'(led));
    ext <= 4'hf;
    wt(8);
    chk("enum_n", 32'h0, 32'(enum_n));
    apb(1'b1, OFS_HSCS, 32'h2);
    wt(2);
    chk("led", 32'h0, 32'(led));
    apb(1'b1, OFS_GPIO_OE, 32'h7);
    ms0 <= 1'b1;
    wt(4);
    ext <= 4'h7;
    wt(8);
    chk("enum_n", 32'h1, 32'(enum_n));
    apb(1'b1, OFS_GPIO_OE, 32'hf);
    wt(2);
    chk("gpio_oe_n", 32'h0, 32'(g_oe_n));
    rdc("status", OFS_STATUS, 32'h20);
    apb(1'b0, 8'h1c, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    chk("unmapped", 32'h0, rd);
    pri <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h1);
    wt(6);
    chk("srst_n", 32'h0, 32'(srst_n));
    chk("speed_oe_n", 32'h0, 32'(sp_oe_n));
    chk("speed_out", 32'h0, 32'(sp_out));
    apb(1'b1, OFS_CTRL, 32'h0);
    wt(RW - 2);
    chk("srst_n", 32'h0, 32'(srst_n));
    wt(8);
    chk("srst_n", 32'h1, 32'(srst_n));
    apb(1'b1, OFS_CTRL, 32'h2);
    wt(RW - 2);
    chk("srst_n", 32'h0, 32'(srst_n));
    wt(8);
    chk("srst_n", 32'h1, 32'(srst_n));
    rdc("ctrl", OFS_CTRL, 32'h0);
    msk <= 1'b1;
    arst_n <= 1'b0;
    wt(2);
    arst_n <= 1'b1;
    wsr();
    rdc("mask", OFS_CLKCTRL, 32'h3ff);
    chk("clk_high", 32'h3ff, 32'(sclk));
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
